/* File: hdl/arm_pkg.sv */
// Package: register map, field layout, timing and carrier types for the readback/margin block
`default_nettype none
package arm_pkg;
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Converter and channel geometry
  localparam int NUM_CH = 8;
  localparam int RES_W = 12;
  localparam int ACC_W = 16;
  localparam int NUM_DAC = 4;
  localparam int CODE_W = 8;
  localparam logic [RES_W-1:0] FULL_SCALE = 12'hfff;
  localparam logic [CODE_W-1:0] MIDCODE = 8'h7f;
  localparam logic [3:0] AVG_LAST_PASS = 4'hf;
  localparam int AVG_SHIFT = 4;
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CHSEL = 8'h01;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h02;
  localparam logic [ADDR_W-1:0] REG_WARN = 8'h03;
  localparam logic [ADDR_W-1:0] REG_DAC_EN = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RANGE = 8'h05;
  localparam logic [ADDR_W-1:0] REG_LIM_MODE = 8'h06;
  localparam logic [ADDR_W-1:0] REG_LIMIT0 = 8'h10;
  localparam logic [ADDR_W-1:0] REG_RESULT0 = 8'h20;
  localparam logic [ADDR_W-1:0] REG_CODE0 = 8'h30;
  localparam logic [ADDR_W-1:0] REG_LOWER0 = 8'h34;
  localparam logic [ADDR_W-1:0] REG_UPPER0 = 8'h38;
  // Control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CONT = 1;
  localparam int CTRL_AVG = 2;
  // Reset values
  localparam logic [RES_W-1:0] LIMIT_RST = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_RST = 8'h7f;
  localparam logic [CODE_W-1:0] LOWER_RST = 8'h00;
  localparam logic [CODE_W-1:0] UPPER_RST = 8'hff;
  // Timing: per-channel slot and buffer tracking phase
  localparam int CLK_MHZ = 20;
  localparam int CONV_TIME_US = 500;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int TRACK_TIME_NS = 10000;
  localparam int TRACK_CYCLES = (TRACK_TIME_NS * CLK_MHZ + 999) / 1000;
  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } arm_bus_req_s;
  // One margin converter's drive to the analog side
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [1:0] range;
    logic track;
    logic drive;
  } arm_dac_out_s;
endpackage : arm_pkg
`default_nettype wire

/* File: hdl/arm_readback_margin.sv */
// Readback scheduler, limit supervision and margin converter control
//
// Local design decisions: the plain strobed port and the address map.
`default_nettype none
// Overview of operation
// RL1: Mux steps through any selected channel subset
// RL2: Single pass stops; continuous repeats forever
// RL3: Averaging runs sixteen passes per result
// RL4: Results update only at cycle end
// RL5: Results are 12-bit unsigned codes
// RL6: One limit per channel, over or under
// RL7: Crossed limit warns status and sequencer
// RL8: Start by bus write or sequencer
// RL9: Each selected channel takes about 500 us
// RL10: Four converters take 8-bit codes
// RL11: Four selectable midcode offset ranges
// RL12: Output linear in code around offset
// RL13: Code span +128 / -127 around midcode
// RL14: Enable tracks pin first, then drives
// RL15: Host does closed-loop margining steps
// RL16: Host margins by writing new code
// RL17: Applied code clamped between lower/upper
// RL18: Lower above upper holds buffer off
// RL19: Warnings follow comparison, never latched
// RL20: Compare whenever a result updates
module arm_readback_margin #(
  parameter int CONV_CYC = arm_pkg::CONV_CYCLES,
  parameter int TRACK_CYC = arm_pkg::TRACK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire arm_pkg::arm_bus_req_s bus_req,
  output logic [arm_pkg::DATA_W-1:0] bus_rdata,
  // Converter front end
  output logic [2:0] adc_mux_sel,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [arm_pkg::RES_W-1:0] adc_data,
  // Sequencing engine link
  input wire logic se_rr_start,
  output logic [arm_pkg::NUM_CH-1:0] se_warn,
  // Margin converters
  output arm_pkg::arm_dac_out_s [arm_pkg::NUM_DAC-1:0] dac_out
);

  // Scheduler states
  typedef enum logic [1:0] {ARM_IDLE, ARM_START, ARM_WAIT} arm_state_e;

  // Lowest selected channel at or above start; bit 3 flags none left
  function automatic logic [3:0] find_sel(input logic [7:0] sel, input logic [3:0] start);
    logic [3:0] hit;
    hit = 4'h8;
    for (int i = 7; i >= 0; i--)
    begin
      if (sel[i] && (4'(i) >= start))
      begin
        hit = 4'(i);
      end
    end
    return hit;
  endfunction : find_sel

  // Applied code: written code held inside the limits
  function automatic logic [7:0] clamp(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    if (c < lo)
    begin
      return lo;
    end
    else if (c > hi)
    begin
      return hi;
    end
    return c;
  endfunction : clamp

  // Software settings
  logic run_cont; // Continuous walk
  logic run_avg; // Sixteen-pass averaging
  logic [7:0] ch_sel; // Channels to convert
  logic [7:0] lim_over; // 1: maximum bound, 0: minimum bound
  logic [arm_pkg::RES_W-1:0] limit [arm_pkg::NUM_CH]; // One threshold per channel
  logic [3:0] dac_en; // Converter enables
  logic [7:0] dac_range; // Two bits per converter
  logic [7:0] code [arm_pkg::NUM_DAC]; // Written codes
  logic [7:0] lower [arm_pkg::NUM_DAC]; // Lower clamp
  logic [7:0] upper [arm_pkg::NUM_DAC]; // Upper clamp
  // Scheduler state
  arm_state_e state;
  logic [2:0] ch; // Channel in conversion
  logic [3:0] pass_cnt; // Averaging pass count
  logic [15:0] slot_cnt; // Cycles spent in this slot
  logic got; // Sample taken this slot
  // Results
  logic [arm_pkg::ACC_W-1:0] acc [arm_pkg::NUM_CH]; // Running sums
  logic [arm_pkg::RES_W-1:0] result [arm_pkg::NUM_CH]; // Published codes
  // Buffer enable sequencing
  logic [15:0] track_cnt [arm_pkg::NUM_DAC];

  // Decoded strobes and scheduler events
  logic wr_ctrl;
  logic start_req;
  logic stop_req;
  logic capture;
  logic slot_done;
  logic [3:0] next_ch;
  logic [3:0] first_ch;
  logic pass_end;
  logic publish;

  assign wr_ctrl = bus_req.wr && (bus_req.addr == arm_pkg::REG_CTRL);
  // Start from a bus write or a sequencer state entry
  assign start_req = (wr_ctrl && bus_req.wdata[arm_pkg::CTRL_RUN]) || se_rr_start; // RL8
  assign stop_req = wr_ctrl && !bus_req.wdata[arm_pkg::CTRL_RUN];
  assign capture = (state == ARM_WAIT) && adc_done && !got;
  // Slot ends only when the sample is in and the slot time is spent
  assign slot_done = (state == ARM_WAIT) && got && (slot_cnt >= 16'(CONV_CYC - 1)); // RL9
  assign next_ch = find_sel(ch_sel, {1'b0, ch} + 4'h1); // RL1
  assign first_ch = find_sel(ch_sel, 4'h0); // RL1
  assign pass_end = slot_done && next_ch[3];
  // Averaging holds results back until the sixteenth pass
  assign publish = pass_end && (!run_avg || (pass_cnt == arm_pkg::AVG_LAST_PASS)); // RL3 RL4

  // Software-written settings
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      run_cont <= 1'b0;
      run_avg <= 1'b0;
      ch_sel <= 8'h00;
      lim_over <= 8'hff;
      dac_en <= 4'h0;
      dac_range <= 8'h00;
      for (int i = 0; i < arm_pkg::NUM_CH; i++)
      begin
        limit[i] <= arm_pkg::LIMIT_RST;
      end
      for (int d = 0; d < arm_pkg::NUM_DAC; d++)
      begin
        code[d] <= arm_pkg::CODE_RST;
        lower[d] <= arm_pkg::LOWER_RST;
        upper[d] <= arm_pkg::UPPER_RST;
      end
    end
    else if (bus_req.wr)
    begin
      // Decode by offset; unmapped writes are dropped
      if (wr_ctrl)
      begin
        run_cont <= bus_req.wdata[arm_pkg::CTRL_CONT]; // RL2
        run_avg <= bus_req.wdata[arm_pkg::CTRL_AVG];
      end
      if (bus_req.addr == arm_pkg::REG_CHSEL)
      begin
        ch_sel <= bus_req.wdata[7:0]; // RL1
      end
      if (bus_req.addr == arm_pkg::REG_LIM_MODE)
      begin
        lim_over <= bus_req.wdata[7:0]; // RL6
      end
      if (bus_req.addr == arm_pkg::REG_DAC_EN)
      begin
        dac_en <= bus_req.wdata[3:0];
      end
      if (bus_req.addr == arm_pkg::REG_RANGE)
      begin
        dac_range <= bus_req.wdata[7:0]; // RL11
      end
      if (bus_req.addr[7:3] == arm_pkg::REG_LIMIT0[7:3])
      begin
        limit[bus_req.addr[2:0]] <= bus_req.wdata[arm_pkg::RES_W-1:0]; // RL6
      end
      if (bus_req.addr[7:2] == arm_pkg::REG_CODE0[7:2])
      begin
        code[bus_req.addr[1:0]] <= bus_req.wdata[7:0]; // RL10
      end
      if (bus_req.addr[7:2] == arm_pkg::REG_LOWER0[7:2])
      begin
        lower[bus_req.addr[1:0]] <= bus_req.wdata[7:0];
      end
      if (bus_req.addr[7:2] == arm_pkg::REG_UPPER0[7:2])
      begin
        upper[bus_req.addr[1:0]] <= bus_req.wdata[7:0];
      end
    end
  end

  // Round-robin scheduler
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= ARM_IDLE;
      ch <= 3'h0;
      pass_cnt <= 4'h0;
      slot_cnt <= 16'h0000;
      got <= 1'b0;
      adc_start <= 1'b0;
      adc_mux_sel <= 3'h0;
    end
    else
    begin
      adc_start <= 1'b0;
      if (stop_req)
      begin
        // Software stop abandons the walk; partial sums are dropped
        state <= ARM_IDLE;
      end
      else
      begin
        case (state)
          ARM_IDLE:
          begin
            // Empty selection gives nothing to walk
            if (start_req && !first_ch[3])
            begin
              ch <= first_ch[2:0];
              pass_cnt <= 4'h0;
              state <= ARM_START;
            end
          end
          ARM_START:
          begin
            adc_mux_sel <= ch; // RL1
            adc_start <= 1'b1;
            slot_cnt <= 16'h0000;
            got <= 1'b0;
            state <= ARM_WAIT;
          end
          ARM_WAIT:
          begin
            slot_cnt <= slot_cnt + 16'h0001;
            if (capture)
            begin
              got <= 1'b1;
            end
            if (slot_done && !next_ch[3])
            begin
              ch <= next_ch[2:0];
              state <= ARM_START;
            end
            else if (pass_end)
            begin
              pass_cnt <= publish ? 4'h0 : pass_cnt + 4'h1; // RL3
              // Single pass stops; continuous or unfinished averaging walks again
              if (run_cont || !publish || first_ch[3])
              begin
                ch <= first_ch[2:0];
                state <= first_ch[3] ? ARM_IDLE : ARM_START; // RL2
              end
              else
              begin
                state <= ARM_IDLE; // RL2
              end
            end
          end
          default:
          begin
            state <= ARM_IDLE;
          end
        endcase
      end
    end
  end

  // Sums and published results
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < arm_pkg::NUM_CH; i++)
      begin
        acc[i] <= 16'h0000;
        result[i] <= 12'h000;
      end
    end
    else if (state == ARM_IDLE)
    begin
      // Fresh sums for every new run
      for (int i = 0; i < arm_pkg::NUM_CH; i++)
      begin
        acc[i] <= 16'h0000;
      end
    end
    else if (capture)
    begin
      acc[ch] <= acc[ch] + {4'h0, adc_data}; // RL5
    end
    else if (publish)
    begin
      // Only channels walked this run are replaced
      for (int i = 0; i < arm_pkg::NUM_CH; i++)
      begin
        if (ch_sel[i])
        begin
          result[i] <= run_avg ? acc[i][arm_pkg::AVG_SHIFT +: arm_pkg::RES_W] : acc[i][arm_pkg::RES_W-1:0]; // RL4
        end
        acc[i] <= 16'h0000;
      end
    end
  end

  // Live limit comparison; a new result is judged on the next edge
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      se_warn <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < arm_pkg::NUM_CH; i++)
      begin
        se_warn[i] <= lim_over[i] ? (result[i] > limit[i]) : (result[i] < limit[i]); // RL6 RL7 RL19 RL20
      end
    end
  end

  // Margin converter drive: track first, then switch to the code
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (int d = 0; d < arm_pkg::NUM_DAC; d++)
      begin
        dac_out[d] <= '{code: arm_pkg::CODE_RST, range: 2'b00, track: 1'b0, drive: 1'b0};
        track_cnt[d] <= 16'h0000;
      end
    end
    else
    begin
      for (int d = 0; d < arm_pkg::NUM_DAC; d++)
      begin
        dac_out[d].code <= clamp(code[d], lower[d], upper[d]); // RL17 RL12 RL13
        dac_out[d].range <= dac_range[2*d +: 2]; // RL11
        // Inverted limits lock the buffer off regardless of enable
        if (!dac_en[d] || (lower[d] > upper[d])) // RL18
        begin
          dac_out[d].track <= 1'b0;
          dac_out[d].drive <= 1'b0;
          track_cnt[d] <= 16'h0000;
        end
        else if (track_cnt[d] < 16'(TRACK_CYC))
        begin
          // Follows the pin without driving so the rail sees no glitch
          dac_out[d].track <= 1'b1; // RL14
          track_cnt[d] <= track_cnt[d] + 16'h0001;
        end
        else
        begin
          dac_out[d].track <= 1'b0;
          dac_out[d].drive <= 1'b1; // RL14
        end
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bus_rdata <= 16'h0000;
    end
    else
    begin
      bus_rdata <= 16'h0000;
      if (bus_req.rd)
      begin
        if (bus_req.addr == arm_pkg::REG_CTRL)
        begin
          bus_rdata <= {13'h0000, run_avg, run_cont, state != ARM_IDLE};
        end
        else if (bus_req.addr == arm_pkg::REG_CHSEL)
        begin
          bus_rdata <= {8'h00, ch_sel};
        end
        else if (bus_req.addr == arm_pkg::REG_STATUS)
        begin
          bus_rdata <= {8'h00, pass_cnt, ch, state != ARM_IDLE};
        end
        else if (bus_req.addr == arm_pkg::REG_WARN)
        begin
          bus_rdata <= {8'h00, se_warn}; // RL7 RL19
        end
        else if (bus_req.addr == arm_pkg::REG_DAC_EN)
        begin
          bus_rdata <= {12'h000, dac_en};
        end
        else if (bus_req.addr == arm_pkg::REG_RANGE)
        begin
          bus_rdata <= {8'h00, dac_range};
        end
        else if (bus_req.addr == arm_pkg::REG_LIM_MODE)
        begin
          bus_rdata <= {8'h00, lim_over};
        end
        else if (bus_req.addr[7:3] == arm_pkg::REG_LIMIT0[7:3])
        begin
          bus_rdata <= {4'h0, limit[bus_req.addr[2:0]]};
        end
        else if (bus_req.addr[7:3] == arm_pkg::REG_RESULT0[7:3])
        begin
          bus_rdata <= {4'h0, result[bus_req.addr[2:0]]};
        end
        else if (bus_req.addr[7:2] == arm_pkg::REG_CODE0[7:2])
        begin
          bus_rdata <= {8'h00, code[bus_req.addr[1:0]]};
        end
        else if (bus_req.addr[7:2] == arm_pkg::REG_LOWER0[7:2])
        begin
          bus_rdata <= {8'h00, lower[bus_req.addr[1:0]]};
        end
        else if (bus_req.addr[7:2] == arm_pkg::REG_UPPER0[7:2])
        begin
          bus_rdata <= {8'h00, upper[bus_req.addr[1:0]]};
        end
      end
    end
  end

endmodule : arm_readback_margin
`default_nettype wire

/* File: test/adc_readback_dac_margin_ctrl_tb.sv */
// Self-checking bench for the readback and margin block
`default_nettype none
module adc_readback_dac_margin_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TRK = 4;
  logic sys_clk, rst_n, start, done, se_start, slow, wob;
  arm_pkg::arm_bus_req_s req;
  logic [15:0] rdata, q;
  logic [2:0] mux;
  logic [11:0] data;
  logic [7:0] warn, sel, md, c, lo, hi;
  arm_pkg::arm_dac_out_s [3:0] dac;
  logic [11:0] base [8], res [8], lim [8];
  logic [2:0] starts [$];
  integer seed;
  int err_total, cmp_count, cyc, n, nt;
  arm_readback_margin #(.CONV_CYC(20), .TRACK_CYC(TRK)) arm_readback_margin_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata), .adc_mux_sel(mux), .adc_start(start), .adc_done(done),
    .adc_data(data), .se_rr_start(se_start), .se_warn(warn), .dac_out(dac));
  arm_adc_model arm_adc_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .adc_mux_sel(mux), .adc_start(start),
    .adc_done(done), .adc_data(data), .slow(slow), .wob(wob), .base(base));
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr
  // Register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    rd(a, q);
    chk(q, e);
  endtask : rc
  // Poll busy flag with a bound
  task automatic wait_idle(input int lim_n);
    for (int i = 0; i < lim_n && q[0] !== 1'b0; i++)
      rd(arm_pkg::REG_STATUS, q);
    chk(16'(q[0]), 16'h0000);
  endtask : wait_idle
  // Expected warnings from mode, results and limits
  function automatic logic [7:0] wexp(input logic [7:0] m);
    logic [7:0] w;
    for (int i = 0; i < 8; i++)
      w[i] = m[i] ? res[i] > lim[i] : res[i] < lim[i];
    return w;
  endfunction : wexp
  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] l, input logic [7:0] h);
    return v < l ? l : (v > h ? h : v);
  endfunction : clamp
  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Start log and hang guard
  always @(posedge sys_clk)
  begin
    if (start)
      starts.push_back(mux);
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    se_start = 1'b0;
    slow = 1'b0;
    wob = 1'b0;
    seed = 94040;
    foreach (base[i]) base[i] = 12'($random(seed));
    base[0] = 12'h000;
    base[7] = 12'hfff;
    // Unwalked channels keep their reset result of zero
    foreach (res[i]) res[i] = 12'h000;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk(16'(dac[0]), 16'h07f0);
    rc(arm_pkg::REG_CODE0, 16'h007f);
    rc(arm_pkg::REG_UPPER0, 16'h00ff);
    rc(arm_pkg::REG_LIMIT0, 16'h0fff);
    rc(8'h7e, 16'h0000);
    // Single pass over a random subset holding both end channels
    sel = 8'($random(seed)) | 8'h81;
    wr(arm_pkg::REG_CHSEL, {8'h00, sel});
    rc(arm_pkg::REG_CHSEL, {8'h00, sel});
    wr(arm_pkg::REG_CTRL, 16'h0001);
    q = 16'h0001;
    wait_idle(500);
    chk(16'(starts.size()), 16'($countones(sel)));
    n = 0;
    for (int i = 0; i < 8; i++)
      if (sel[i])
      begin
        chk(16'(starts[n]), 16'(i));
        n++;
        rc(8'(arm_pkg::REG_RESULT0 + i), 16'(base[i]));
        res[i] = base[i];
      end
    // Limits, both polarities; unselected forced quiet; equal limit on channel 0
    md = 8'($random(seed)) | ~sel;
    for (int i = 0; i < 8; i++)
    begin
      lim[i] = sel[i] ? 12'($random(seed)) : 12'hfff;
      lim[0] = 12'h000;
      wr(8'(arm_pkg::REG_LIMIT0 + i), 16'(lim[i]));
    end
    repeat (2)
    begin
      wr(arm_pkg::REG_LIM_MODE, {8'h00, md});
      repeat (3) @(negedge sys_clk);
      chk(16'(warn), 16'(wexp(md)));
      rc(arm_pkg::REG_WARN, 16'(wexp(md)));
      md = ~md | ~sel;
    end
    // Continuous averaging, then abort
    foreach (base[i]) base[i] = base[i] & 12'h7ff;
    wob <= 1'b1;
    wr(arm_pkg::REG_CTRL, 16'h0007);
    repeat (640 * $countones(sel)) @(posedge sys_clk);
    rd(arm_pkg::REG_STATUS, q);
    chk(16'(sel[q[3:1]]), 16'h0001);
    chk(16'(q[0]), 16'h0001);
    for (int i = 0; i < 8; i++)
      if (sel[i])
        rc(8'(arm_pkg::REG_RESULT0 + i), 16'(base[i] + 12'h007));
    wr(arm_pkg::REG_CTRL, 16'h0000);
    // Force at least one status poll so the abort is really seen
    q = 16'h0001;
    wait_idle(10);
    // Sequencer start with a slow converter
    foreach (base[i]) base[i] = base[i] ^ 12'h00f;
    wob <= 1'b0;
    slow <= 1'b1;
    repeat (30) @(posedge sys_clk);
    se_start <= 1'b1;
    @(posedge sys_clk);
    se_start <= 1'b0;
    repeat (60) @(posedge sys_clk);
    rc(arm_pkg::REG_RESULT0, 16'h0007);
    q = 16'h0001;
    wait_idle(600);
    for (int i = 0; i < 8; i++)
      if (sel[i])
        rc(8'(arm_pkg::REG_RESULT0 + i), 16'(base[i]));
    // Margin converters: clamp, range, tracking, lower above upper
    wr(arm_pkg::REG_RANGE, 16'h001b);
    for (int d = 0; d < 4; d++)
    begin
      c = d == 1 ? 8'h00 : (d == 2 ? 8'hff : 8'($random(seed)));
      lo = d == 3 ? 8'h90 : 8'($random(seed)) & 8'h7f;
      hi = d == 3 ? 8'h10 : 8'($random(seed)) | 8'h80;
      wr(8'(arm_pkg::REG_CODE0 + d), {8'h00, c});
      wr(8'(arm_pkg::REG_LOWER0 + d), {8'h00, lo});
      wr(8'(arm_pkg::REG_UPPER0 + d), {8'h00, hi});
      wr(arm_pkg::REG_DAC_EN, 16'(1 << d));
      nt = 0;
      repeat (TRK + 6) @(negedge sys_clk) nt += int'(dac[d].track === 1'b1);
      chk(16'(nt), d == 3 ? 16'h0000 : 16'(TRK));
      chk(16'(dac[d][3:0]), {12'h000, 2'(3 - d), 1'b0, d != 3});
      if (d != 3)
        chk(16'(dac[d].code), 16'(clamp(c, lo, hi)));
    end
    // Closed-loop host steps on converter 0
    wr(arm_pkg::REG_DAC_EN, 16'h0000);
    wr(arm_pkg::REG_CODE0, 16'h007f);
    wr(arm_pkg::REG_LOWER0, 16'h0000);
    wr(arm_pkg::REG_UPPER0, 16'h00ff);
    wr(arm_pkg::REG_DAC_EN, 16'h0001);
    repeat (TRK + 4) @(negedge sys_clk);
    for (int j = 0; j < 4; j++)
    begin
      c = j == 0 ? 8'h00 : (j == 1 ? 8'hff : 8'($random(seed)));
      wr(arm_pkg::REG_CODE0, {8'h00, c});
      repeat (2) @(negedge sys_clk);
      chk(16'(dac[0]), {4'h0, c, 2'h3, 1'b0, 1'b1});
    end
    report_and_stop();
  end
endmodule : adc_readback_dac_margin_ctrl_tb
`default_nettype wire

/* File: test/arm_adc_model.sv */
// Converter front-end model answering conversion starts
`default_nettype none
module arm_adc_model #(
  parameter int SLOW_CYC = 30
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Converter link
  input wire logic [2:0] adc_mux_sel,
  input wire logic adc_start,
  output logic adc_done,
  output logic [11:0] adc_data,
  // Test controls
  input wire logic slow,
  input wire logic wob,
  input wire logic [11:0] base [8]
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_n; // Cycles left, -1 when idle
  logic [2:0] ch; // Channel of this conversion
  logic [3:0] k [8]; // Per-channel wobble so averages differ from samples
  // One answer per start; data toggles when not valid
  always_ff @(posedge sys_clk)
  begin
    adc_done <= 1'b0;
    if (!rst_n)
    begin
      wait_n <= -1;
      adc_data <= 12'h000;
      foreach (k[i]) k[i] <= 4'h0;
    end
    else if (adc_start)
    begin
      wait_n <= slow ? SLOW_CYC : 1;
      ch <= adc_mux_sel;
    end
    else if (wait_n == 0)
    begin
      adc_done <= 1'b1;
      adc_data <= base[ch] + (wob ? 12'(k[ch]) : 12'h000);
      k[ch] <= k[ch] + 4'h1;
      wait_n <= -1;
    end
    else
    begin
      adc_data <= ~adc_data;
      if (wait_n > 0)
        wait_n <= wait_n - 1;
    end
  end
endmodule : arm_adc_model
`default_nettype wire

/* File: test/arm_chk.sv */
// Port-level assertions for the readback and margin block
`default_nettype none
module arm_chk #(
  parameter int CONV_CYC = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire arm_pkg::arm_bus_req_s bus_req,
  input wire logic [arm_pkg::DATA_W-1:0] bus_rdata,
  // Converter link
  input wire logic [2:0] adc_mux_sel,
  input wire logic adc_start,
  // Margin converters
  input wire arm_pkg::arm_dac_out_s [arm_pkg::NUM_DAC-1:0] dac_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Cycles since last start, saturating so a long gap never wraps
  int since;
  // Start-to-start distance counter
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      since <= CONV_CYC;
    else if (adc_start)
      since <= 0;
    else if (since < CONV_CYC)
      since <= since + 1;
  end
  a_start_one: assert property (adc_start |=> !adc_start)
    else $error("start pulse too long");
  a_slot_len: assert property (adc_start |-> since >= CONV_CYC - 1)
    else $error("conversion slot too short");
  a_mux_hold: assert property ($changed(adc_mux_sel) |-> adc_start)
    else $error("mux moved without a start");
  a_track_excl: assert property (dac_out[0].track |-> !dac_out[0].drive)
    else $error("buffer drives while tracking");
  a_drive_order: assert property ($rose(dac_out[0].drive) |-> $past(dac_out[0].track))
    else $error("drive without tracking first");
  a_code_cause: assert property ($changed(dac_out[0].code) |-> $past(bus_req.wr) || $past(bus_req.wr, 2))
    else $error("code moved without a write");
  a_range_cause: assert property ($changed(dac_out[0].range) |-> $past(bus_req.wr) || $past(bus_req.wr, 2))
    else $error("range moved without a write");
  a_rdata_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
    else $error("read data outside its cycle");
endmodule : arm_chk
bind arm_readback_margin arm_chk #(.CONV_CYC(CONV_CYC)) arm_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .adc_mux_sel(adc_mux_sel), .adc_start(adc_start), .dac_out(dac_out));
`default_nettype wire
